// ===== include/ppmc_regs.vh
// Register indices, control word fields and port C roles
// Assumes byte address = index * 4 inside a 32-byte window
`ifndef PPMC_REGS_VH
`define PPMC_REGS_VH
// Register indices, decoded from paddr[4:2]
`define PPMC_IDX_PORTA 3'h0
`define PPMC_IDX_PORTB 3'h1
`define PPMC_IDX_PORTC 3'h2
`define PPMC_IDX_CTRL 3'h3
`define PPMC_IDX_ISTAT 3'h4
`define PPMC_IDX_ICLR 3'h5
`define PPMC_IDX_IEN 3'h6
// Window address bits
`define PPMC_WIN_HI 4
`define PPMC_WIN_LO 2
// Reset values
`define PPMC_CW_RST 8'h9B
`define PPMC_P_RST 8'h00
`define PPMC_I_RST 2'h0
// Control word fields
`define PPMC_CW_FLAG 7
`define PPMC_CW_MA_HI 6
`define PPMC_CW_MA_LO 5
`define PPMC_CW_DIR_A 4
`define PPMC_CW_DIR_CU 3
`define PPMC_CW_MODE_B 2
`define PPMC_CW_DIR_B 1
`define PPMC_CW_DIR_CL 0
// Single-bit set/clear fields
`define PPMC_SR_HI 3
`define PPMC_SR_LO 1
`define PPMC_SR_VAL 0
// Port C line roles in handshake modes
`define PPMC_PC_INTRB 0
`define PPMC_PC_FLAGB 1
`define PPMC_PC_STBB 2
`define PPMC_PC_INTRA 3
`define PPMC_PC_STBA 4
`define PPMC_PC_IBFA 5
`define PPMC_PC_ACKA 6
`define PPMC_PC_OBFA 7
// Interrupt status bits
`define PPMC_IRQ_A 0
`define PPMC_IRQ_B 1
`endif

// ===== src/ppmc_top.v
// Three-port parallel I/O block with mode 0/1/2 control, APB slave
// Assumes APB master on clk; port pins are asynchronous to clk
//
// Function
// - Registers decoded inside a 32-byte window; host assigns window and interrupt.
// - Modes 0 basic, 1 strobed, 2 bidirectional are supported.
// - Group A is port A plus upper C; group B port B plus lower C.
// - Group A in mode 1 or 2 uses port C bit 3 as interrupt.
// - Mode 0 moves data directly on each read or write, no handshake.
// - Mode 0 outputs hold last value; input lines are pulled up.
// - Mode 1 data ports are input or output, latched both ways.
// - Mode 1 port C halves carry control/status; interrupts with enables.
// - Mode 1 uses six port C lines, three each for handshakes of A and B.
// - Mode 2 only for group A: latched bidirectional A, five C lines.
// - Mode 2 handshakes like mode 1 with interrupt enable controls.
// - One control word sets or clears any single port C bit.
// - Control word bit 7 set means mode and direction definition.
// - Mode 0 directions: bits 4,3,1,0 select input for A,CU,B,CL.
// - Upper and lower port C nibbles take independent directions.
// - Bit 7 clear: bits 3..1 pick port C bit, bit 0 value.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ppmc_regs.vh"
module ppmc_top (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire [31:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire [7:0] pa_in,
  output reg [7:0] pa_out,
  output reg [7:0] pa_oe,
  input wire [7:0] pb_in,
  output reg [7:0] pb_out,
  output reg [7:0] pb_oe,
  input wire [7:0] pc_in,
  output reg [7:0] pc_out,
  output reg [7:0] pc_oe,
  output wire irq
);

  // Full byte mask when a direction bit selects output
  function [7:0] out_mask;
    input in_bit;
    begin
      out_mask = in_bit ? 8'h00 : 8'hFF;
    end
  endfunction

  reg [23:0] pin_s1_r;
  reg [23:0] pin_s2_r;
  reg [7:0] pc_d_r;
  reg [7:0] cw_r;
  reg [7:0] pa_r;
  reg [7:0] pb_r;
  reg [7:0] pc_r;
  reg [7:0] ina_r;
  reg [7:0] inb_r;
  reg ibfa_r;
  reg obfa_r;
  reg ackda_r;
  reg ibfb_r;
  reg obfb_r;
  reg ackdb_r;
  reg intra_d_r;
  reg intrb_d_r;
  reg [1:0] ist_r;
  reg [1:0] ien_r;
  reg [7:0] pc_o_nxt;
  reg [7:0] pc_oe_nxt;
  reg [7:0] pc_rd;
  reg [31:0] rd_nxt;

  // Synchronised pin views
  wire [7:0] pas = pin_s2_r[7:0];
  wire [7:0] pbs = pin_s2_r[15:8];
  wire [7:0] pcs = pin_s2_r[23:16];

  // Mode decode
  wire a_m2 = cw_r[`PPMC_CW_MA_HI];
  wire a_m1 = ~cw_r[`PPMC_CW_MA_HI] & cw_r[`PPMC_CW_MA_LO];
  wire a_hs = a_m1 | a_m2;
  wire a_in = cw_r[`PPMC_CW_DIR_A];
  wire cu_in = cw_r[`PPMC_CW_DIR_CU];
  wire b_m1 = cw_r[`PPMC_CW_MODE_B];
  wire b_in = cw_r[`PPMC_CW_DIR_B];
  wire cl_in = cw_r[`PPMC_CW_DIR_CL];
  wire a_rx = a_m2 | (a_m1 & a_in);
  wire a_tx = a_m2 | (a_m1 & ~a_in);

  // Handshake enables kept in port C latch
  wire inte_ia = pc_r[`PPMC_PC_STBA];
  wire inte_oa = pc_r[`PPMC_PC_ACKA];
  wire inte_b = pc_r[`PPMC_PC_STBB];

  // Strobe and acknowledge edges
  wire stba_fall = pc_d_r[`PPMC_PC_STBA] & ~pcs[`PPMC_PC_STBA];
  wire acka_fall = pc_d_r[`PPMC_PC_ACKA] & ~pcs[`PPMC_PC_ACKA];
  wire acka_rise = ~pc_d_r[`PPMC_PC_ACKA] & pcs[`PPMC_PC_ACKA];
  wire stbb_fall = pc_d_r[`PPMC_PC_STBB] & ~pcs[`PPMC_PC_STBB];
  wire stbb_rise = ~pc_d_r[`PPMC_PC_STBB] & pcs[`PPMC_PC_STBB];

  // Group interrupt requests
  wire intra_rx = ibfa_r & inte_ia;
  wire intra_tx = ackda_r & inte_oa;
  wire intra = a_m2 ? (intra_rx | intra_tx) :
               (a_m1 & (a_in ? intra_rx : intra_tx));
  wire intrb = b_m1 & inte_b &
               (b_in ? ibfb_r : ackdb_r);

  // APB decode, window aliases above bit 4
  wire [2:0] idx = paddr[`PPMC_WIN_HI:`PPMC_WIN_LO];
  wire setup = psel & ~penable & ce;
  wire acc = psel & penable & ce;
  wire wr = acc & pwrite & pstrb[0];
  wire rd = acc & ~pwrite;
  wire [7:0] wd = pwdata[7:0];
  wire wr_a = wr & (idx == `PPMC_IDX_PORTA);
  wire wr_b = wr & (idx == `PPMC_IDX_PORTB);
  wire wr_c = wr & (idx == `PPMC_IDX_PORTC);
  wire wr_cw = wr & (idx == `PPMC_IDX_CTRL);
  wire wr_def = wr_cw & wd[`PPMC_CW_FLAG];
  wire wr_sr = wr_cw & ~wd[`PPMC_CW_FLAG];
  wire wr_clr = wr & (idx == `PPMC_IDX_ICLR);
  wire wr_ien = wr & (idx == `PPMC_IDX_IEN);
  wire rd_a = rd & (idx == `PPMC_IDX_PORTA);
  wire rd_b = rd & (idx == `PPMC_IDX_PORTB);
  wire [2:0] sr_bit = wd[`PPMC_SR_HI:`PPMC_SR_LO];

  // Zero wait states; a frozen block stalls the bus
  assign pready = ce;

  // Interrupt output from enabled sticky bits
  assign irq = |(ist_r & ien_r);

  // Port C read view: pins, latch, or handshake status
  always @* begin
    pc_rd[7:4] = cu_in ? pcs[7:4] : pc_r[7:4];
    pc_rd[3:0] = cl_in ? pcs[3:0] : pc_r[3:0];
    if (a_hs) begin
      pc_rd[`PPMC_PC_INTRA] = intra;
    end
    if (a_m2) begin
      pc_rd[`PPMC_PC_OBFA] = ~obfa_r;
      pc_rd[`PPMC_PC_ACKA] = inte_oa;
      pc_rd[`PPMC_PC_IBFA] = ibfa_r;
      pc_rd[`PPMC_PC_STBA] = inte_ia;
    end else if (a_m1 & a_in) begin
      pc_rd[`PPMC_PC_IBFA] = ibfa_r;
      pc_rd[`PPMC_PC_STBA] = inte_ia;
    end else if (a_m1) begin
      pc_rd[`PPMC_PC_OBFA] = ~obfa_r;
      pc_rd[`PPMC_PC_ACKA] = inte_oa;
    end
    if (b_m1) begin
      pc_rd[`PPMC_PC_STBB] = inte_b;
      pc_rd[`PPMC_PC_FLAGB] = b_in ? ibfb_r : ~obfb_r;
      pc_rd[`PPMC_PC_INTRB] = intrb;
    end
  end

  // Port C pin drive: latch in mode 0, handshakes otherwise
  always @* begin
    pc_o_nxt = pc_r;
    pc_oe_nxt = (out_mask(cu_in) & 8'hF0) | (out_mask(cl_in) & 8'h0F);
    if (a_hs) begin
      pc_o_nxt[`PPMC_PC_INTRA] = intra;
      pc_oe_nxt[`PPMC_PC_INTRA] = 1'b1;
    end
    if (a_rx) begin
      pc_o_nxt[`PPMC_PC_IBFA] = ibfa_r;
      pc_oe_nxt[`PPMC_PC_IBFA] = 1'b1;
      pc_oe_nxt[`PPMC_PC_STBA] = 1'b0;
    end
    if (a_tx) begin
      pc_o_nxt[`PPMC_PC_OBFA] = ~obfa_r;
      pc_oe_nxt[`PPMC_PC_OBFA] = 1'b1;
      pc_oe_nxt[`PPMC_PC_ACKA] = 1'b0;
    end
    if (b_m1) begin
      pc_o_nxt[`PPMC_PC_FLAGB] = b_in ? ibfb_r : ~obfb_r;
      pc_oe_nxt[`PPMC_PC_FLAGB] = 1'b1;
      pc_o_nxt[`PPMC_PC_INTRB] = intrb;
      pc_oe_nxt[`PPMC_PC_INTRB] = 1'b1;
      pc_oe_nxt[`PPMC_PC_STBB] = 1'b0;
    end
  end

  // Read data mux
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (idx)
      `PPMC_IDX_PORTA: begin
        if (a_m2 | (a_m1 & a_in)) begin
          rd_nxt[7:0] = ina_r;
        end else begin
          rd_nxt[7:0] = a_in ? pas : pa_r;
        end
      end
      `PPMC_IDX_PORTB: begin
        if (b_m1 & b_in) begin
          rd_nxt[7:0] = inb_r;
        end else begin
          rd_nxt[7:0] = b_in ? pbs : pb_r;
        end
      end
      `PPMC_IDX_PORTC: rd_nxt[7:0] = pc_rd;
      `PPMC_IDX_CTRL: rd_nxt[7:0] = cw_r;
      `PPMC_IDX_ISTAT: rd_nxt[1:0] = ist_r;
      `PPMC_IDX_IEN: rd_nxt[1:0] = ien_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Two-stage pin synchronisers and edge history
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 24'hFF_FFFF;
      pin_s2_r <= 24'hFF_FFFF;
      pc_d_r <= 8'hFF;
    end else if (ce) begin
      pin_s1_r <= {pc_in, pb_in, pa_in};
      pin_s2_r <= pin_s1_r;
      pc_d_r <= pin_s2_r[23:16];
    end
  end

  // APB answer captured in the setup cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
      pslverr <= (idx == 3'h7);
    end
  end

  // Control word and port latches
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cw_r <= `PPMC_CW_RST;
      pa_r <= `PPMC_P_RST;
      pb_r <= `PPMC_P_RST;
      pc_r <= `PPMC_P_RST;
    end else if (ce) begin
      if (wr_def) begin
        cw_r <= wd;
        pa_r <= `PPMC_P_RST;
        pb_r <= `PPMC_P_RST;
        pc_r <= `PPMC_P_RST;
      end else begin
        if (wr_a) begin
          pa_r <= wd;
        end
        if (wr_b) begin
          pb_r <= wd;
        end
        if (wr_sr) begin
          pc_r[sr_bit] <= wd[`PPMC_SR_VAL];
        end else if (wr_c) begin
          pc_r <= wd;
        end
      end
    end
  end

  // Group A handshake flags and input latch
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ina_r <= `PPMC_P_RST;
      ibfa_r <= 1'b0;
      obfa_r <= 1'b0;
      ackda_r <= 1'b0;
    end else if (ce) begin
      if (wr_def) begin
        ibfa_r <= 1'b0;
        obfa_r <= 1'b0;
        ackda_r <= 1'b0;
      end else begin
        if (a_rx & stba_fall) begin
          ina_r <= pas;
          ibfa_r <= 1'b1;
        end else if (rd_a) begin
          ibfa_r <= 1'b0;
        end
        if (a_tx & wr_a) begin
          obfa_r <= 1'b1;
        end else if (a_tx & acka_fall) begin
          obfa_r <= 1'b0;
        end
        if (a_tx & acka_rise) begin
          ackda_r <= 1'b1;
        end else if (wr_a) begin
          ackda_r <= 1'b0;
        end
      end
    end
  end

  // Group B handshake flags and input latch
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inb_r <= `PPMC_P_RST;
      ibfb_r <= 1'b0;
      obfb_r <= 1'b0;
      ackdb_r <= 1'b0;
    end else if (ce) begin
      if (wr_def) begin
        ibfb_r <= 1'b0;
        obfb_r <= 1'b0;
        ackdb_r <= 1'b0;
      end else if (b_m1) begin
        if (b_in & stbb_fall) begin
          inb_r <= pbs;
          ibfb_r <= 1'b1;
        end else if (rd_b) begin
          ibfb_r <= 1'b0;
        end
        if (~b_in & wr_b) begin
          obfb_r <= 1'b1;
        end else if (~b_in & stbb_fall) begin
          obfb_r <= 1'b0;
        end
        if (~b_in & stbb_rise) begin
          ackdb_r <= 1'b1;
        end else if (wr_b) begin
          ackdb_r <= 1'b0;
        end
      end
    end
  end

  // Sticky interrupt status; a new event beats a clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intra_d_r <= 1'b0;
      intrb_d_r <= 1'b0;
      ist_r <= `PPMC_I_RST;
      ien_r <= `PPMC_I_RST;
    end else if (ce) begin
      intra_d_r <= intra;
      intrb_d_r <= intrb;
      ist_r <= (ist_r & ~({2{wr_clr}} & wd[1:0])) |
               {intrb & ~intrb_d_r, intra & ~intra_d_r};
      if (wr_ien) begin
        ien_r <= wd[1:0];
      end
    end
  end

  // Registered pin drive
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pa_out <= 8'h00;
      pa_oe <= 8'h00;
      pb_out <= 8'h00;
      pb_oe <= 8'h00;
      pc_out <= 8'h00;
      pc_oe <= 8'h00;
    end else if (ce) begin
      pa_out <= pa_r;
      pa_oe <= a_m2 ? out_mask(pcs[`PPMC_PC_ACKA]) : out_mask(a_in);
      pb_out <= pb_r;
      pb_oe <= out_mask(b_in);
      pc_out <= pc_o_nxt;
      pc_oe <= pc_oe_nxt;
    end
  end

endmodule
`default_nettype wire

// ===== verification/ppmc_chk.sv
// Checker on the top pins of the parallel port block
// Assumes one clock domain and async active-low reset
`timescale 1ns/10ps
`default_nettype none
module ppmc_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pc_out,
  input wire logic [7:0] pc_oe,
  input wire logic irq
);
  // Accepted write and its register index
  wire wr = psel & penable & pwrite & pstrb[0] & ce;
  wire [2:0] ix = paddr[4:2];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Control word writes of both formats
  sequence cw_mode;
    wr && ix == 3'h3 && pwdata[7];
  endsequence
  sequence cw_bit;
    wr && ix == 3'h3 && !pwdata[7] && pc_oe == 8'hff;
  endsequence
  reset_idle_a: assert property ($rose(rst_n) |-> (pa_oe | pc_oe) == 8'h00)
    else $error("lines driven after reset");
  no_wait_a: assert property (psel && penable |-> pready == ce)
    else $error("transfer stalled");
  unmapped_err_a: assert property (psel && !penable && ce && ix == 3'h7 |=> pslverr)
    else $error("no error outside map");
  dir_set_a: assert property (cw_mode ##0 pwdata[6:5] == 2'h0 && !pwdata[2] |=> ##1
    {pa_oe, pc_oe} == {{8{!$past(pwdata[4], 2)}}, {4{!$past(pwdata[3], 2)}}, {4{!$past(pwdata[0], 2)}}})
    else $error("direction mismatch");
  intr_line_a: assert property (cw_mode ##0 pwdata[6:5] != 2'h0 |=> ##1 pc_oe[3])
    else $error("interrupt line not driven");
  bit_write_a: assert property (cw_bit |=> ##1 pc_out[$past(pwdata[3:1], 2)] == $past(pwdata[0], 2))
    else $error("single bit write lost");
  irq_mask_a: assert property (wr && ix == 3'h6 && pwdata[1:0] == 2'h0 |=> !irq)
    else $error("masked irq high");
  out_hold_a: assert property (pa_oe == 8'hff && !(wr && (ix == 3'h0 || ix == 3'h3)) |=> ##1 $stable(pa_out))
    else $error("output changed");
endmodule
bind ppmc_top ppmc_chk u_chk (.clk(clk), .rst_n(rst_n), .ce(ce), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .pa_out(pa_out), .pa_oe(pa_oe), .pc_out(pc_out), .pc_oe(pc_oe), .irq(irq));
`default_nettype wire

// ===== verification/ppmc_pins.sv
// Far-side pin model: pull-ups plus optional outside drivers
// Assumes per-line drive enables from the block
`timescale 1ns/10ps
`default_nettype none
module ppmc_pins (
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pb_out,
  input wire logic [7:0] pb_oe,
  input wire logic [7:0] pc_out,
  input wire logic [7:0] pc_oe,
  input wire logic [7:0] xa,
  input wire logic [7:0] xb,
  input wire logic [7:0] xc,
  input wire logic [2:0] xen,
  output wire logic [7:0] pa_in,
  output wire logic [7:0] pb_in,
  output wire logic [7:0] pc_in
);
  // Block drive wins, then outside drive, else the pull-up
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & (xen[0] ? xa : 8'hff));
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & (xen[1] ? xb : 8'hff));
  assign pc_in = (pc_oe & pc_out) | (~pc_oe & (xen[2] ? xc : 8'hff));
endmodule
`default_nettype wire

// ===== verification/ppmc_tb_top.sv
// Self-checking bench for the parallel port block
// Assumes zero-wait APB slave and pins looped through the pull-up model
`timescale 1ns/10ps
`default_nettype none
module ppmc_tb_top;
  // Byte addresses, index times four
  localparam [7:0] RA = 8'h00, RB = 8'h04, RC = 8'h08, RW = 8'h0C;
  localparam [7:0] RS = 8'h10, RK = 8'h14, RE = 8'h18;
  logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, irq, ve;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0] pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, pc_in, pc_out, pc_oe, xa, xb, xc;
  logic [2:0] xen;
  int errors, n_tests;
  ppmc_top u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
    .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe), .irq(irq));
  ppmc_pins u_pins (.pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe), .pc_out(pc_out),
    .pc_oe(pc_oe), .xa(xa), .xb(xb), .xc(xc), .xen(xen), .pa_in(pa_in), .pb_in(pb_in), .pc_in(pc_in));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic nx(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One APB transfer, bounded wait for pready
  task automatic xf(logic [7:0] a, logic w, logic [7:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h00_0000, a};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      errors++;
      wrap_up();
    end
    rd = prdata;
    ve = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_reset;
    xf(RW, 1'b0, 8'h00);
    chk("cw", rd, 32'h0000_009b);
    chk("idle", {pa_oe, pb_oe, pc_oe, 7'h00, irq}, 32'h0000_0000);
    $display("t_reset done");
  endtask
  task automatic t_dirs;
    for (int n = 0; n < 16; n++) begin
      xf(RW, 1'b1, {3'b100, n[3], n[2], 1'b0, n[1], n[0]});
      nx(1);
      chk("dir", {pa_oe, pc_oe[7:4], pb_oe, pc_oe[3:0]}, {{8{~n[3]}}, {4{~n[2]}}, {8{~n[1]}}, {4{~n[0]}}});
    end
    $display("t_dirs done");
  endtask
  task automatic t_out;
    xf(RW, 1'b1, 8'h80);
    xf(RA, 1'b1, 8'h12);
    xf(RB, 1'b1, 8'h34);
    xf(RC, 1'b1, 8'h56);
    nx(1);
    chk("out", {pa_out, pb_out, pc_out}, 24'h12_3456);
    nx(6);
    xf(RA, 1'b0, 8'h00);
    chk("hold", {rd[7:0], pa_out}, 16'h1212);
    $display("t_out done");
  endtask
  task automatic t_in;
    xf(RW, 1'b1, 8'h9b);
    @(posedge clk);
    xa <= 8'h5a;
    xen <= 3'b001;
    nx(3);
    xf(RA, 1'b0, 8'h00);
    chk("pin_a", rd, 32'h0000_005a);
    xf(RB, 1'b0, 8'h00);
    chk("pull_b", rd, 32'h0000_00ff);
    $display("t_in done");
  endtask
  task automatic t_bsr;
    xf(RW, 1'b1, 8'h80);
    xf(RC, 1'b1, 8'h00);
    for (int n = 0; n < 8; n++) begin
      xf(RW, 1'b1, {4'h0, n[2:0], 1'b1});
      nx(1);
      chk("bit_set", pc_out, 8'h01 << n);
      xf(RW, 1'b1, {4'h0, n[2:0], 1'b0});
      nx(1);
      chk("bit_clr", pc_out, 8'h00);
    end
    $display("t_bsr done");
  endtask
  task automatic t_err;
    xf(8'h1c, 1'b0, 8'h00);
    chk("unmapped", {rd[30:0], ve}, 32'h0000_0001);
    xf(8'h2c, 1'b0, 8'h00);
    chk("alias", rd, 32'h0000_0080);
    $display("t_err done");
  endtask
  // Group A strobed input raises the interrupt on port C bit 3
  task automatic t_irq;
    xf(RW, 1'b1, 8'hc0);
    nx(1);
    chk("m2_intr", pc_oe[3], 1'b1);
    @(posedge clk);
    xc <= 8'hff;
    xa <= 8'hc3;
    xen <= 3'b101;
    xf(RW, 1'b1, 8'hb0);
    xf(RW, 1'b1, 8'h09);
    xf(RE, 1'b1, 8'h01);
    @(posedge clk);
    xc <= 8'hef;
    nx(4);
    @(posedge clk);
    xc <= 8'hff;
    xa <= 8'h00;
    nx(6);
    chk("intr", {pc_out[3], irq}, 2'b11);
    xf(RA, 1'b0, 8'h00);
    chk("latch", rd, 32'h0000_00c3);
    xf(RE, 1'b1, 8'h00);
    nx(1);
    chk("mask", irq, 1'b0);
    xf(RE, 1'b1, 8'h01);
    nx(1);
    chk("unmask", irq, 1'b1);
    xf(RK, 1'b1, 8'h03);
    nx(1);
    chk("clear", irq, 1'b0);
    xf(RS, 1'b0, 8'h00);
    chk("stat", rd, 32'h0000_0000);
    $display("t_irq done");
  endtask
  // Group A strobed output and group B strobed input side by side
  task automatic t_m1;
    xf(RW, 1'b1, 8'ha6);
    xf(RW, 1'b1, 8'h0d);
    xf(RW, 1'b1, 8'h05);
    xf(RE, 1'b1, 8'h03);
    @(posedge clk);
    xb <= 8'h3c;
    xen <= 3'b111;
    xf(RA, 1'b1, 8'h5a);
    xf(RK, 1'b1, 8'h03);
    nx(1);
    chk("obf_a", {pa_out, pc_out[7], irq}, 10'h168);
    @(posedge clk);
    xc <= 8'hbb;
    nx(4);
    @(posedge clk);
    xc <= 8'hff;
    nx(6);
    chk("m1_hs", {pc_out[7], pc_out[3], pc_out[1:0], irq}, 5'h1f);
    xf(RS, 1'b0, 8'h00);
    chk("stat_ab", rd, 32'h0000_0003);
    xf(RB, 1'b0, 8'h00);
    chk("latch_b", rd, 32'h0000_003c);
    nx(1);
    chk("ibf_b", pc_out[1:0], 2'h0);
    $display("t_m1 done");
  endtask
  // A write held while the clock enable is low lands once it returns
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    fork
      xf(RA, 1'b1, 8'hc3);
      begin
        repeat (3) @(posedge clk);
        chk("frozen", {pready, pa_out}, 9'h05a);
        ce <= 1'b1;
      end
    join
    nx(1);
    chk("thawed", pa_out, 8'hc3);
    $display("t_freeze done");
  endtask
  initial begin
    errors = 0;
    n_tests = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    {psel, penable, pwrite, ve} = 4'h0;
    {paddr, pwdata, rd} = 96'h0;
    {xa, xb, xc, xen} = 27'h0;
    repeat (5) @(posedge clk);
    // Release stands for host activation: window, interrupt, index 01
    rst_n <= 1'b1;
    t_reset();
    t_dirs();
    t_out();
    t_in();
    t_bsr();
    t_err();
    t_irq();
    t_m1();
    t_freeze();
    wrap_up();
  end
endmodule
`default_nettype wire
